// File: verilog/csm_pkg.sv
// constants and types for the cascaded converter mode control
package csm_pkg;
  // ---------------------------------------------------------------
  // register map (word index on the plain register port)
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  ADR_HW_CTRL0  = 4'h0;
  localparam logic [3:0]  ADR_CONV_STAT = 4'h1;
  localparam logic [3:0]  ADR_STAT_CLR  = 4'h2;
  localparam logic [3:0]  ADR_IRQ_EN    = 4'h3;
  localparam logic [3:0]  ADR_STATE     = 4'h4;
  // hardware_control_word_zero fields
  localparam int          CTL_BOOST_EN  = 0;
  localparam int          CTL_BOOST_V   = 1;
  localparam int          CTL_PWM_AUTO  = 3;
  localparam int          CTL_PWM_BY_WK = 4;
  localparam int          CTL_IO_OV_RST = 5;
  localparam int          CTL_TLAG      = 6;
  localparam logic [7:0]  CTL_RESET     = 8'h00;
  // converter_status_register bits
  localparam int          NSTAT         = 8;
  localparam int          ST_SW_OPEN    = 0;
  localparam int          ST_SW_SHORT   = 1;
  localparam int          ST_BST_OPEN   = 2;
  localparam int          ST_BST_SHORT  = 3;
  localparam int          ST_GND_LOSS   = 4;
  localparam int          ST_BOOST_ACT  = 5;
  localparam int          ST_CMD_FAULT  = 6;
  localparam int          ST_PFM_PWM    = 7;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          SW_HZ         = 2_000_000;
  localparam int          SW_PERIOD     = CLK_HZ / SW_HZ;
  localparam logic [7:0]  SW_LAST       = 8'(SW_PERIOD - 1);
  localparam logic [7:0]  SS_DUTY_MIN   = 8'h10;
  localparam logic [7:0]  SS_DUTY_STEP  = 8'h08;
  localparam logic [7:0]  SS_HOLD_PER   = 8'h08;
  localparam logic [7:0]  SS_STEP_PER   = 8'h04;
  localparam logic [7:0]  DUTY_FULL     = 8'hff;
  localparam logic [15:0] TLAG_UNIT     = 16'h0040;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    M_NORMAL, M_STOP, M_RESTART, M_SLEEP, M_FAILSAFE
  } csm_mode_t;
  typedef enum logic [1:0] {
    SS_OFF, SS_HOLD, SS_RAMP, SS_CLOSED
  } csm_ss_t;
endpackage : csm_pkg

// File: verilog/csm_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module csm_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } csm_sync_st_t;

  csm_sync_st_t r_q;
  csm_sync_st_t r_d;

  always_comb begin
    r_d    = r_q;
    r_d.s1 = async_i;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign sync_o = r_q.s2;
endmodule : csm_sync
`default_nettype wire

// File: verilog/csm_ctrl.sv
// mode gating, soft start and status for the boost/buck converter pair
// Function
// (RL1) both converters run in normal, stop, restart; off in sleep and fail-safe
// (RL2) buck uses fixed pwm in normal, restart; in stop only after transition
// (RL3) entering stop switches buck to pfm automatically
// (RL4) soft start at power-up and on sleep or fail-safe to restart
// (RL5) soft start opens loop at minimum duty for limited periods
// (RL6) ramp duty by fixed step, limited periods each, until target reached
// (RL7) at target close the loop and follow loop duty in pwm
// (RL8) pwm duty may saturate at full on-time with low input
// (RL9) switch node open/short recorded; status causes no mode change
// (RL10) status flags boost pin open/short and lost ground
// (RL11) software enables boost by register bit in normal mode
// (RL12) four boost voltage settings; selection fixes turn-on threshold
// (RL13) enabled boost stays usable in stop and restart
// (RL14) boost on below threshold, off above threshold plus hysteresis
// (RL15) step-up active flag set when boost actually switched on
// (RL16) voltage selection change while enabled is discarded, fault flag set
// (RL17) io overvoltage drives fail output only with enable bit and pin open
// (RL18) boost switches at fixed frequency in pwm
// (RL19) soft start duty, step and periods are design constants
`timescale 1ns/1ps
`default_nettype none
module csm_ctrl (
  input  wire logic                       CLOCK_I,
  input  wire logic                       RESET_N_I,
  input  wire logic [csm_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [7:0]                 WDATA_I,
  input  wire logic                       WR_I,
  input  wire logic                       RD_I,
  output logic      [7:0]                 RDATA_O,
  input  wire csm_pkg::csm_mode_t         MODE_I,
  input  wire logic                       STOP_CMD_I,
  input  wire logic [7:0]                 LOOP_DUTY_I,
  input  wire logic                       VOUT_OK_I,
  input  wire logic                       PFM_OVER_I,
  input  wire logic                       WAKE_PIN_I,
  input  wire logic                       VS_BELOW_TH_I,
  input  wire logic                       VS_ABOVE_HYST_I,
  input  wire logic                       SW_OPEN_I,
  input  wire logic                       SW_SHORT_I,
  input  wire logic                       BST_OPEN_I,
  input  wire logic                       BST_SHORT_I,
  input  wire logic                       GND_LOSS_I,
  input  wire logic                       IO_OV_I,
  input  wire logic                       PWR_CFG_OPEN_I,
  output logic                            BUCK_EN_O,
  output logic                            BUCK_PWM_O,
  output logic      [7:0]                 BUCK_DUTY_O,
  output logic                            BUCK_SW_TICK_O,
  output logic                            BOOST_ON_O,
  output logic      [1:0]                 BOOST_VSEL_O,
  output logic                            BOOST_SW_TICK_O,
  output logic                            FAIL_O,
  output logic                            IRQ_O
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int NPIN = 12;
  logic [NPIN-1:0] pin_s;
  logic vout_ok_s, pfm_over_s, wake_s, vs_low_s, vs_high_s;
  logic sw_open_s, sw_short_s, bst_open_s, bst_short_s, gnd_s, io_ov_s, pwr_cfg_s;

  csm_sync #(.W(NPIN)) u_sync (
    .clock_i   (CLOCK_I),
    .reset_n_i (RESET_N_I),
    .async_i   ({VOUT_OK_I, PFM_OVER_I, WAKE_PIN_I, VS_BELOW_TH_I, VS_ABOVE_HYST_I,
                 SW_OPEN_I, SW_SHORT_I, BST_OPEN_I, BST_SHORT_I, GND_LOSS_I,
                 IO_OV_I, PWR_CFG_OPEN_I}),
    .sync_o    (pin_s)
  );

  assign {vout_ok_s, pfm_over_s, wake_s, vs_low_s, vs_high_s,
          sw_open_s, sw_short_s, bst_open_s, bst_short_s, gnd_s,
          io_ov_s, pwr_cfg_s} = pin_s;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    csm_pkg::csm_mode_t  mode_prev;
    csm_pkg::csm_ss_t    ss;
    logic [7:0]          sw_cnt;
    logic                sw_tick;
    logic [7:0]          per_cnt;
    logic [7:0]          duty;
    logic                stop_pwm;
    logic [15:0]         tlag_cnt;
    logic                tlag_done;
    logic                buck_pwm;
    logic                boost_on;
    logic                fail;
    logic [7:0]          ctrl;
    logic [7:0]          stat;
    logic [7:0]          irq_en;
    logic [7:0]          rdata;
  } csm_st_t;

  csm_st_t r_q;
  csm_st_t r_d;

  logic             active;
  logic [7:0]       ev;
  logic [8:0]       duty_sum;
  logic [15:0]      tlag_len;

  always_comb begin
    r_d      = r_q;
    ev       = '0;
    duty_sum = '0;
    tlag_len = '0;
    active   = (MODE_I == csm_pkg::M_NORMAL) || (MODE_I == csm_pkg::M_STOP) ||
               (MODE_I == csm_pkg::M_RESTART);                            // RL1
    r_d.mode_prev = MODE_I;

    // -------------------------------------------------------------
    // switching period divider, shared by both stages
    // -------------------------------------------------------------
    r_d.sw_tick = 1'b0;
    if (!active) begin
      r_d.sw_cnt = '0;
    end else if (r_q.sw_cnt == csm_pkg::SW_LAST) begin
      r_d.sw_cnt  = '0;
      r_d.sw_tick = 1'b1;                                                 // RL18
    end else begin
      r_d.sw_cnt = r_q.sw_cnt + 8'h01;
    end

    // -------------------------------------------------------------
    // soft start sequencer
    // -------------------------------------------------------------
    case (r_q.ss)
      csm_pkg::SS_OFF: begin
        // any way out of an off mode ends in restart, so ramp again
        if (active) begin
          r_d.ss      = csm_pkg::SS_HOLD;                                 // RL4
          r_d.duty    = csm_pkg::SS_DUTY_MIN;
          r_d.per_cnt = '0;
        end
      end
      csm_pkg::SS_HOLD: begin
        r_d.duty = csm_pkg::SS_DUTY_MIN;                                  // RL5
        if (r_q.sw_tick) begin
          if (r_q.per_cnt == csm_pkg::SS_HOLD_PER - 8'h01) begin
            r_d.ss      = csm_pkg::SS_RAMP;                               // RL19
            r_d.per_cnt = '0;
          end else begin
            r_d.per_cnt = r_q.per_cnt + 8'h01;
          end
        end
      end
      csm_pkg::SS_RAMP: begin
        if (vout_ok_s) begin
          r_d.ss = csm_pkg::SS_CLOSED;                                    // RL7
        end else if (r_q.sw_tick) begin
          if (r_q.per_cnt == csm_pkg::SS_STEP_PER - 8'h01) begin
            r_d.per_cnt = '0;
            duty_sum    = {1'b0, r_q.duty} + {1'b0, csm_pkg::SS_DUTY_STEP};
            r_d.duty    = duty_sum[8] ? csm_pkg::DUTY_FULL : duty_sum[7:0]; // RL6
          end else begin
            r_d.per_cnt = r_q.per_cnt + 8'h01;
          end
        end
      end
      csm_pkg::SS_CLOSED: begin
        // loop duty passes unclamped so full on-time is reachable
        r_d.duty = LOOP_DUTY_I;                                           // RL7 RL8
      end
      default: begin
        r_d.ss = csm_pkg::SS_OFF;
      end
    endcase
    if (!active) begin
      r_d.ss   = csm_pkg::SS_OFF;                                         // RL1
      r_d.duty = '0;
    end

    // -------------------------------------------------------------
    // buck modulation per mode
    // -------------------------------------------------------------
    tlag_len = csm_pkg::TLAG_UNIT *
               {14'h0000, r_q.ctrl[csm_pkg::CTL_TLAG +: 2]} + csm_pkg::TLAG_UNIT;
    if ((MODE_I == csm_pkg::M_STOP) &&
        ((r_q.mode_prev != csm_pkg::M_STOP) || STOP_CMD_I)) begin
      // fresh stop entry or repeated stop command: back to pfm
      r_d.stop_pwm  = 1'b0;                                               // RL3
      r_d.tlag_cnt  = '0;
      r_d.tlag_done = 1'b0;
    end else if (MODE_I == csm_pkg::M_STOP) begin
      if (!r_q.tlag_done) begin
        if (r_q.tlag_cnt == tlag_len - 16'h0001) begin
          r_d.tlag_done = 1'b1;
        end else begin
          r_d.tlag_cnt = r_q.tlag_cnt + 16'h0001;
        end
      end
      if (r_q.ctrl[csm_pkg::CTL_PWM_AUTO] && r_q.tlag_done && pfm_over_s &&
          !r_q.stop_pwm) begin
        r_d.stop_pwm        = 1'b1;                                       // RL2
        ev[csm_pkg::ST_PFM_PWM] = 1'b1;
      end
    end else begin
      r_d.stop_pwm = 1'b0;
    end
    case (MODE_I)
      csm_pkg::M_NORMAL,
      csm_pkg::M_RESTART: r_d.buck_pwm = 1'b1;                            // RL2
      csm_pkg::M_STOP: begin
        if (r_q.mode_prev != csm_pkg::M_STOP) begin
          r_d.buck_pwm = 1'b0;                                            // RL3
        end else if (r_q.ctrl[csm_pkg::CTL_PWM_AUTO]) begin
          r_d.buck_pwm = r_d.stop_pwm;                                    // RL2
        end else if (r_q.ctrl[csm_pkg::CTL_PWM_BY_WK]) begin
          r_d.buck_pwm = wake_s;                                          // RL2
        end else begin
          r_d.buck_pwm = 1'b0;                                            // RL3
        end
      end
      default: r_d.buck_pwm = 1'b0;
    endcase

    // -------------------------------------------------------------
    // boost hysteretic enable
    // -------------------------------------------------------------
    if (!active || !r_q.ctrl[csm_pkg::CTL_BOOST_EN]) begin
      r_d.boost_on = 1'b0;                                                // RL1
    end else if (vs_low_s) begin
      r_d.boost_on = 1'b1;                                                // RL13 RL14
    end else if (vs_high_s) begin
      r_d.boost_on = 1'b0;                                                // RL14
    end
    ev[csm_pkg::ST_BOOST_ACT] = r_q.boost_on;                             // RL15

    // -------------------------------------------------------------
    // fail output from io overvoltage
    // -------------------------------------------------------------
    r_d.fail = io_ov_s && r_q.ctrl[csm_pkg::CTL_IO_OV_RST] && pwr_cfg_s;  // RL17

    // -------------------------------------------------------------
    // register port
    // -------------------------------------------------------------
    ev[csm_pkg::ST_SW_OPEN]   = sw_open_s;                                // RL9
    ev[csm_pkg::ST_SW_SHORT]  = sw_short_s;                               // RL9
    ev[csm_pkg::ST_BST_OPEN]  = bst_open_s;                               // RL10
    ev[csm_pkg::ST_BST_SHORT] = bst_short_s;                              // RL10
    ev[csm_pkg::ST_GND_LOSS]  = gnd_s;                                    // RL10
    if (WR_I) begin
      case (ADDR_I)
        csm_pkg::ADR_HW_CTRL0: begin
          if (r_q.ctrl[csm_pkg::CTL_BOOST_EN] &&
              (WDATA_I[csm_pkg::CTL_BOOST_V +: 2] !=
               r_q.ctrl[csm_pkg::CTL_BOOST_V +: 2])) begin
            // whole command dropped, not just the voltage field
            ev[csm_pkg::ST_CMD_FAULT] = 1'b1;                             // RL16
          end else begin
            r_d.ctrl = WDATA_I;                                           // RL12
            // enabling only takes in normal; clearing always allowed
            if (MODE_I != csm_pkg::M_NORMAL) begin
              r_d.ctrl[csm_pkg::CTL_BOOST_EN] = WDATA_I[csm_pkg::CTL_BOOST_EN] &
                                                r_q.ctrl[csm_pkg::CTL_BOOST_EN]; // RL11
            end
          end
        end
        csm_pkg::ADR_STAT_CLR: r_d.stat = r_q.stat & ~WDATA_I;
        csm_pkg::ADR_IRQ_EN:   r_d.irq_en = WDATA_I;
        default: begin
        end
      endcase
    end
    // set beats clear; status never feeds back into mode or config
    r_d.stat = r_d.stat | ev;                                             // RL9

    r_d.rdata = '0;
    if (RD_I) begin
      case (ADDR_I)
        csm_pkg::ADR_HW_CTRL0:  r_d.rdata = r_q.ctrl;
        csm_pkg::ADR_CONV_STAT: r_d.rdata = r_q.stat;
        csm_pkg::ADR_IRQ_EN:    r_d.rdata = r_q.irq_en;
        csm_pkg::ADR_STATE:     r_d.rdata = {r_q.ss, r_q.buck_pwm, r_q.boost_on,
                                             r_q.fail, active, 2'b00};
        default:                r_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      r_q           <= '0;
      r_q.mode_prev <= csm_pkg::M_SLEEP;
      r_q.ss        <= csm_pkg::SS_OFF;
      r_q.ctrl      <= csm_pkg::CTL_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign RDATA_O         = r_q.rdata;
  assign BUCK_EN_O       = r_q.ss != csm_pkg::SS_OFF;
  assign BUCK_PWM_O      = r_q.buck_pwm;
  assign BUCK_DUTY_O     = r_q.duty;
  assign BUCK_SW_TICK_O  = r_q.sw_tick & r_q.buck_pwm;
  assign BOOST_ON_O      = r_q.boost_on;
  assign BOOST_VSEL_O    = r_q.ctrl[csm_pkg::CTL_BOOST_V +: 2];           // RL12
  assign BOOST_SW_TICK_O = r_q.sw_tick & r_q.boost_on;                    // RL18
  assign FAIL_O          = r_q.fail;
  assign IRQ_O           = |(r_q.stat & r_q.irq_en);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);

  AST_OFF_IN_LOW_POWER: assert property ( // RL1
    (MODE_I == csm_pkg::M_SLEEP) |=> (!BOOST_ON_O && r_q.duty == 8'h00))
    else $error("converters not off in sleep");
  AST_PWM_NORMAL: assert property ( // RL2
    (MODE_I == csm_pkg::M_NORMAL) |=> BUCK_PWM_O)
    else $error("buck not pwm in normal");
  AST_PFM_ON_STOP: assert property ( // RL3
    (MODE_I == csm_pkg::M_STOP && r_q.mode_prev != csm_pkg::M_STOP) |=> !BUCK_PWM_O)
    else $error("buck not pfm on stop entry");
  AST_SS_RESTART: assert property ( // RL4
    (MODE_I == csm_pkg::M_RESTART && r_q.mode_prev == csm_pkg::M_SLEEP &&
     r_q.ss == csm_pkg::SS_OFF) |=> (r_q.ss == csm_pkg::SS_HOLD))
    else $error("soft start missing on restart");
  AST_HOLD_MIN: assert property ( // RL5
    (r_q.ss == csm_pkg::SS_HOLD) |-> (BUCK_DUTY_O == csm_pkg::SS_DUTY_MIN))
    else $error("hold duty not minimum");
  AST_RAMP_STEP: assert property ( // RL6
    (r_q.ss == csm_pkg::SS_RAMP && $past(r_q.ss) == csm_pkg::SS_RAMP &&
     r_q.duty != $past(r_q.duty)) |-> (r_q.duty - $past(r_q.duty) ==
     csm_pkg::SS_DUTY_STEP || r_q.duty == csm_pkg::DUTY_FULL))
    else $error("ramp step wrong");
  AST_CLOSE_LOOP: assert property ( // RL7
    (active && r_q.ss == csm_pkg::SS_RAMP && vout_ok_s) |=>
    (r_q.ss == csm_pkg::SS_CLOSED))
    else $error("loop not closed at target");
  AST_BOOST_HYST: assert property ( // RL14
    (active && r_q.ctrl[csm_pkg::CTL_BOOST_EN] && vs_low_s) |=> BOOST_ON_O)
    else $error("boost not on below threshold");
  AST_BOOST_ACT: assert property ( // RL15
    BOOST_ON_O |=> r_q.stat[csm_pkg::ST_BOOST_ACT])
    else $error("step-up active flag missing");
  AST_VSEL_GUARD: assert property ( // RL16
    (WR_I && ADDR_I == csm_pkg::ADR_HW_CTRL0 && r_q.ctrl[csm_pkg::CTL_BOOST_EN] &&
     WDATA_I[2:1] != BOOST_VSEL_O) |=> ($stable(BOOST_VSEL_O) &&
     r_q.stat[csm_pkg::ST_CMD_FAULT]))
    else $error("selection change not discarded");
  AST_FAIL_GATE: assert property ( // RL17
    FAIL_O |-> $past(r_q.ctrl[csm_pkg::CTL_IO_OV_RST] && pwr_cfg_s && io_ov_s))
    else $error("fail output without gating");
endmodule : csm_ctrl
`default_nettype wire

// File: tb/csm_filter_model.sv
// behavioural model of the inductors, diode and output capacitors
`timescale 1ns/1ps
`default_nettype none
module csm_filter_model #(
  parameter logic [11:0] VOUT_TARGET = 12'h200,
  parameter logic [4:0]  VS_FULL     = 5'h10
) (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       buck_en_i,
  input  wire logic [7:0] buck_duty_i,
  input  wire logic       buck_tick_i,
  input  wire logic       boost_on_i,
  input  wire logic       supply_low_i,
  output logic            vout_ok_o,
  output logic            vs_below_o,
  output logic            vs_above_o
);
  logic [11:0] charge_q;
  logic [4:0]  vs_q;
  // --------------------------------------------------------------
  // output charge and boosted supply
  // --------------------------------------------------------------
  // charge grows by duty per switching period, dumped when buck is off
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !buck_en_i)
      charge_q <= 12'h000;
    else if (buck_tick_i && charge_q < VOUT_TARGET)
      charge_q <= charge_q + {4'h0, buck_duty_i};
    if (!reset_n_i)
      vs_q <= 5'h00;
    else if (boost_on_i && vs_q != VS_FULL)
      vs_q <= vs_q + 5'h01;
    else if (!boost_on_i && vs_q != 5'h00)
      vs_q <= vs_q - 5'h01;
  end
  assign vout_ok_o  = charge_q >= VOUT_TARGET;
  // slow decay gives the hysteresis band a real width
  assign vs_below_o = supply_low_i && vs_q == 5'h00;
  assign vs_above_o = vs_q == VS_FULL;
endmodule : csm_filter_model
`default_nettype wire

// File: tb/tb_csm_ctrl.sv
// self-checking bench for the converter mode control
`timescale 1ns/1ps
`default_nettype none
module tb_csm_ctrl;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [3:0]         addr = 4'h0;
  logic [7:0]         wdata = 8'h00;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  csm_pkg::csm_mode_t mode = csm_pkg::M_NORMAL;
  logic               stop_cmd = 1'b0;
  logic               pfm_over = 1'b0;
  logic               supply_low = 1'b0;
  logic [4:0]         faults = 5'h00;
  logic               io_ov = 1'b0;
  logic               pwr_cfg_open = 1'b1;
  logic               wake = 1'b0;
  logic [7:0]         loop_duty = 8'hff;
  logic [7:0]         rdata, buck_duty, d;
  logic [1:0]         boost_vsel;
  logic               vout_ok, vs_below, vs_above, buck_en, buck_pwm;
  logic               buck_tick, boost_on, boost_tick, fail, irq;
  int                 num_errors = 0;
  int                 num_checks = 0;
  int                 i;
  always #20 clk = ~clk;
  csm_ctrl dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MODE_I(mode), .STOP_CMD_I(stop_cmd),
    .LOOP_DUTY_I(loop_duty), .VOUT_OK_I(vout_ok), .PFM_OVER_I(pfm_over), .WAKE_PIN_I(wake),
    .VS_BELOW_TH_I(vs_below), .VS_ABOVE_HYST_I(vs_above), .SW_OPEN_I(faults[0]),
    .SW_SHORT_I(faults[1]), .BST_OPEN_I(faults[2]), .BST_SHORT_I(faults[3]),
    .GND_LOSS_I(faults[4]), .IO_OV_I(io_ov), .PWR_CFG_OPEN_I(pwr_cfg_open), .BUCK_EN_O(buck_en),
    .BUCK_PWM_O(buck_pwm), .BUCK_DUTY_O(buck_duty), .BUCK_SW_TICK_O(buck_tick),
    .BOOST_ON_O(boost_on), .BOOST_VSEL_O(boost_vsel), .BOOST_SW_TICK_O(boost_tick),
    .FAIL_O(fail), .IRQ_O(irq));
  csm_filter_model u_filter (.clock_i(clk), .reset_n_i(rst_n), .buck_en_i(buck_en),
    .buck_duty_i(buck_duty), .buck_tick_i(buck_tick), .boost_on_i(boost_on),
    .supply_low_i(supply_low), .vout_ok_o(vout_ok), .vs_below_o(vs_below),
    .vs_above_o(vs_above));
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // a wait that ran out ends the run at once
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      $display("ERROR wait expected %0d seen %0d", lim - 1, n);
      stop_test();
    end
  endtask : tmo
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic wduty(input logic [7:0] v, input int lim);
    for (i = 0; i < lim && buck_duty !== v; i++) @(negedge clk);
    tmo(i, lim);
  endtask : wduty
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_soft_start;
    for (i = 0; i < 10 && buck_en !== 1'b1; i++) @(negedge clk);
    tmo(i, 10);
    chk("duty_min", buck_duty, csm_pkg::SS_DUTY_MIN);
    rreg(csm_pkg::ADR_HW_CTRL0, d);
    chk("ctrl_reset", d, csm_pkg::CTL_RESET);
    wt(60);
    chk("duty_hold", buck_duty, csm_pkg::SS_DUTY_MIN);
    wduty(8'h18, 200);
    wt(30);
    chk("duty_step", buck_duty, 8'h18);
    wduty(8'h20, 100);
    wduty(8'hff, 2000);
    rreg(csm_pkg::ADR_STATE, d);
    chk("ss_closed", d[7:6], csm_pkg::SS_CLOSED);
    chk("pwm_normal", buck_pwm, 8'h01);
    @(posedge clk) loop_duty <= 8'h80;
    wt(4);
    chk("loop_duty", buck_duty, 8'h80);
    @(posedge clk) loop_duty <= 8'hff;
    wt(4);
    chk("full_duty", buck_duty, csm_pkg::DUTY_FULL);
    $display("test soft_start done");
  endtask : t_soft_start
  task automatic t_modes;
    @(posedge clk) mode <= csm_pkg::M_SLEEP;
    wt(4);
    chk("sleep_en", buck_en, 8'h00);
    chk("sleep_duty", buck_duty, 8'h00);
    @(posedge clk) mode <= csm_pkg::M_RESTART;
    wt(3);
    chk("restart_duty", buck_duty, csm_pkg::SS_DUTY_MIN);
    wduty(8'hff, 2000);
    chk("restart_pwm", buck_pwm, 8'h01);
    wreg(csm_pkg::ADR_HW_CTRL0, 8'h08);
    @(posedge clk) mode <= csm_pkg::M_STOP;
    pfm_over <= 1'b1;
    wt(4);
    chk("stop_pfm", buck_pwm, 8'h00);
    chk("stop_en", buck_en, 8'h01);
    wt(40);
    chk("tlag_pfm", buck_pwm, 8'h00);
    for (i = 0; i < 100 && buck_pwm !== 1'b1; i++) @(negedge clk);
    tmo(i, 100);
    rreg(csm_pkg::ADR_CONV_STAT, d);
    chk("auto_evt", d[csm_pkg::ST_PFM_PWM], 8'h01);
    @(posedge clk) stop_cmd <= 1'b1;
    pfm_over <= 1'b0;
    @(posedge clk) stop_cmd <= 1'b0;
    wt(4);
    chk("cmd_pfm", buck_pwm, 8'h00);
    wreg(csm_pkg::ADR_HW_CTRL0, 8'h10);
    @(posedge clk) wake <= 1'b1;
    wt(4);
    chk("wake_pwm", buck_pwm, 8'h01);
    @(posedge clk) wake <= 1'b0;
    wt(4);
    chk("wake_pfm", buck_pwm, 8'h00);
    @(posedge clk) mode <= csm_pkg::M_NORMAL;
    wreg(csm_pkg::ADR_HW_CTRL0, 8'h00);
    wreg(csm_pkg::ADR_STAT_CLR, 8'hff);
    $display("test modes done");
  endtask : t_modes
  task automatic t_boost;
    wreg(csm_pkg::ADR_HW_CTRL0, 8'h05);
    @(posedge clk) supply_low <= 1'b1;
    for (i = 0; i < 50 && boost_on !== 1'b1; i++) @(negedge clk);
    tmo(i, 50);
    chk("vsel", boost_vsel, 8'h02);
    rreg(csm_pkg::ADR_CONV_STAT, d);
    chk("boost_act", d[csm_pkg::ST_BOOST_ACT], 8'h01);
    wreg(csm_pkg::ADR_HW_CTRL0, 8'h07);
    wt(2);
    chk("vsel_kept", boost_vsel, 8'h02);
    rreg(csm_pkg::ADR_CONV_STAT, d);
    chk("cmd_fault", d[csm_pkg::ST_CMD_FAULT], 8'h01);
    wreg(csm_pkg::ADR_IRQ_EN, 8'h40);
    wt(2);
    chk("irq_set", irq, 8'h01);
    wreg(csm_pkg::ADR_STAT_CLR, 8'h40);
    wt(2);
    chk("irq_clr", irq, 8'h00);
    wreg(csm_pkg::ADR_IRQ_EN, 8'h00);
    rreg(4'hf, d);
    chk("unmapped", d, 8'h00);
    @(posedge clk) mode <= csm_pkg::M_STOP;
    wt(4);
    for (i = 0; i < 60 && boost_on !== 1'b1; i++) @(negedge clk);
    tmo(i, 60);
    @(posedge clk) mode <= csm_pkg::M_NORMAL;
    supply_low <= 1'b0;
    // disable with the selection unchanged, else the write is refused
    wreg(csm_pkg::ADR_HW_CTRL0, 8'h04);
    $display("test boost done");
  endtask : t_boost
  task automatic t_faults;
    wreg(csm_pkg::ADR_STAT_CLR, 8'hff);
    @(posedge clk) faults <= 5'h1f;
    wt(5);
    @(posedge clk) faults <= 5'h00;
    rreg(csm_pkg::ADR_CONV_STAT, d);
    chk("pin_faults", d[4:0], 8'h1f);
    chk("fault_en", buck_en, 8'h01);
    chk("fault_duty", buck_duty, 8'hff);
    @(posedge clk) io_ov <= 1'b1;
    wt(5);
    chk("fail_off", fail, 8'h00);
    wreg(csm_pkg::ADR_HW_CTRL0, 8'h20);
    wt(3);
    chk("fail_on", fail, 8'h01);
    chk("vsel_free", boost_vsel, 8'h00);
    @(posedge clk) pwr_cfg_open <= 1'b0;
    wt(5);
    chk("fail_cfg_pin", fail, 8'h00);
    $display("test faults done");
  endtask : t_faults
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_soft_start();
    t_modes();
    t_boost();
    t_faults();
    stop_test();
  end
endmodule : tb_csm_ctrl
`default_nettype wire
